// ===== hdl/wtac_pkg.sv
`default_nettype none
package wtac_pkg;
    // ======================================================
    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_RELOAD_HIGH   = 12'h30E;
    localparam logic [11:0] IDX_RELOAD_LOW    = 12'h30F;
    localparam logic [11:0] IDX_FLAG_CLEAR    = 12'h310;
    localparam logic [11:0] IDX_STATUS        = 12'h311;
    localparam logic [11:0] IDX_RX_STRENGTH   = 12'h312;
    localparam logic [11:0] IDX_FREQ_LIMIT    = 12'h315;
    localparam logic [11:0] IDX_IMAGE_CAL     = 12'h319;
    localparam logic [11:0] IDX_SHUTDOWN      = 12'h322;
    localparam logic [11:0] IDX_RX_POWER      = 12'h324;
    localparam logic [11:0] IDX_WAKE_CONFIG   = 12'h330;

    // ======================================================
    // Field positions
    localparam int FLAG_CLEAR_BIT     = 0;
    localparam int CAL_ENABLE_BIT     = 1;
    localparam int ST_LIVE_BIT        = 0;
    localparam int ST_LATCHED_BIT     = 1;
    localparam int ST_COLD_BIT        = 2;
    localparam int ST_LEVEL_BIT       = 3;
    localparam int ST_SETTLED_BIT     = 4;
    localparam int ST_CAL_DONE_BIT    = 5;
    localparam int ST_CAL_FAIL_BIT    = 6;
    localparam int IMG_OVERWRITE_BIT  = 5;
    localparam int IMG_FREQ_LSB       = 3;
    localparam int IMG_LEVEL_LSB      = 0;
    localparam int SHUTDOWN_REQ_BIT   = 0;
    localparam int CFG_ARM_BIT        = 0;
    localparam int CFG_RUN_BIT        = 1;
    localparam int CFG_XTAL_EN_BIT    = 2;

    // ======================================================
    // Reset values and masks
    localparam logic [7:0] RST_RELOAD       = 8'h00;
    localparam logic [7:0] RST_FREQ_LIMIT   = 8'h32;
    localparam logic [7:0] RST_IMAGE_CAL    = 8'h00;
    localparam logic [7:0] RST_RX_POWER     = 8'h00;
    localparam logic [7:0] RST_WAKE_CONFIG  = 8'h00;
    localparam logic [7:0] MASK_IMAGE_CAL   = 8'h3F;
    localparam logic [7:0] MASK_RX_POWER    = 8'h1F;
    localparam logic [7:0] MASK_WAKE_CONFIG = 8'h07;

    // Synchronised pin inputs, one bit each
    localparam int PIN_TICK    = 0;
    localparam int PIN_LEVEL   = 1;
    localparam int PIN_SETTLED = 2;
    localparam int PIN_DONE    = 3;
    localparam int PIN_FAIL    = 4;
    localparam int PIN_COLD    = 5;
    localparam int PIN_CS      = 6;
    localparam int PIN_COUNT   = 7;
endpackage : wtac_pkg
`default_nettype wire

// ===== hdl/wtac_regs.sv
`default_nettype none
// How it works
// - Low reload byte, write-only, resets zero
// - Enabled timer reaching zero raises wake
// - Timer decrements once per prescaler tick
// - High reload byte applies on low write
// - Wake only while arm bit set
// - Flag-clear bit 0 clears both flags
// - Cal enable; status bit 5 shows done
// - Status bit 6 shows calibration error
// - Status bit 4 shows crystal settled
// - Status bit 3 shows live crystal level
// - Cold start flag sticky until cleared
// - Timeout flag latched until cleared
// - Status bit 0 live counter-zero
// - Received power byte, dBm is value-107
// - Limit resets 50, loads half bandwidth
// - Two-bit image source frequency select
// - Three-bit image source level
// - Overwrite enable bit resets zero
// - Shutdown only while chip select high
// - Five receive power enables reset zero
module wtac_regs
    import wtac_pkg::*;
#(
    parameter int ADDR_W  = 14,
    parameter int TIMER_W = 16
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    output var  logic [31:0]        prdata,
    output var  logic               pready,
    output var  logic               pslverr,
    input  wire logic               wake_tick,
    input  wire logic               slow_crystal_level,
    input  wire logic               slow_crystal_settled,
    input  wire logic               rc_osc_cal_done,
    input  wire logic               rc_osc_cal_fail,
    input  wire logic               cold_start,
    input  wire logic               chip_select,
    input  wire logic               packet_received,
    input  wire logic [7:0]         rx_power_value,
    input  wire logic               receive_state_entry,
    input  wire logic [8:0]         if_bandwidth_khz,
    output var  logic               wake_event,
    output var  logic               timeout_live_event,
    output var  logic               wake_arm,
    output var  logic               slow_crystal_osc_enable,
    output var  logic               rc_osc_cal_enable,
    output var  logic [7:0]         pull_in_limit,
    output var  logic               image_cal_overwrite_enable,
    output var  logic [1:0]         image_cal_frequency,
    output var  logic [2:0]         image_cal_level,
    output var  logic               shutdown_initiate,
    output var  logic               converter_power_enable,
    output var  logic               strength_detector_power_enable,
    output var  logic               if_filter_power_enable,
    output var  logic               mixer_power_enable,
    output var  logic               low_noise_amp_power_enable
);
    // ======================================================
    // Pin synchronisers
    // ======================================================
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_sync;

    always_comb begin
        pin_raw              = '0;
        pin_raw[PIN_TICK]    = wake_tick;
        pin_raw[PIN_LEVEL]   = slow_crystal_level;
        pin_raw[PIN_SETTLED] = slow_crystal_settled;
        pin_raw[PIN_DONE]    = rc_osc_cal_done;
        pin_raw[PIN_FAIL]    = rc_osc_cal_fail;
        pin_raw[PIN_COLD]    = cold_start;
        pin_raw[PIN_CS]      = chip_select;
    end

    wtac_sync3 #(
        .WIDTH    (PIN_COUNT)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pin_raw),
        .sync_out (pin_sync)
    );

    // ======================================================
    // APB decode
    // ======================================================
    logic [11:0] reg_index;
    logic        addr_aligned;
    logic        setup_phase;
    logic        write_strobe;
    logic        hit;
    logic [7:0]  wbyte;

    assign reg_index    = paddr[13:2];
    assign addr_aligned = (paddr[1:0] == 2'b00);
    assign setup_phase  = psel && !penable;
    assign write_strobe = psel && penable && pready && pwrite && !pslverr;
    assign wbyte        = pwdata[7:0];

    always_comb begin
        hit = 1'b0;
        unique case (reg_index)
            IDX_RELOAD_HIGH, IDX_RELOAD_LOW, IDX_FLAG_CLEAR,
            IDX_STATUS, IDX_RX_STRENGTH, IDX_FREQ_LIMIT,
            IDX_IMAGE_CAL, IDX_SHUTDOWN, IDX_RX_POWER,
            IDX_WAKE_CONFIG: hit = addr_aligned;
            default:         hit = 1'b0;
        endcase
    end

    function automatic logic wr_to(input logic [11:0] idx);
        return write_strobe && (reg_index == idx);
    endfunction

    // ======================================================
    // Software registers
    // ======================================================
    logic [7:0]         reload_high_staged;
    logic [TIMER_W-1:0] reload_value;
    logic [7:0]         image_cal_reg;
    logic [7:0]         rx_power_reg;
    logic [7:0]         wake_config;
    logic               shutdown_req_bit;
    logic               flag_clear_pulse;
    logic [7:0]         rx_power_readback;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_high_staged <= RST_RELOAD;
            reload_value       <= '0;
        end else begin
            if (wr_to(IDX_RELOAD_HIGH)) begin
                reload_high_staged <= wbyte;
            end
            // The staged high byte is only committed here, so a
            // half-written value never reaches the counter
            if (wr_to(IDX_RELOAD_LOW)) begin
                reload_value <= {reload_high_staged, wbyte};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            image_cal_reg <= RST_IMAGE_CAL;
            rx_power_reg  <= RST_RX_POWER;
            wake_config   <= RST_WAKE_CONFIG;
            shutdown_req_bit  <= 1'b0;
            rc_osc_cal_enable <= 1'b0;
        end else begin
            if (wr_to(IDX_IMAGE_CAL)) begin
                image_cal_reg <= wbyte & MASK_IMAGE_CAL;
            end
            if (wr_to(IDX_RX_POWER)) begin
                rx_power_reg <= wbyte & MASK_RX_POWER;
            end
            if (wr_to(IDX_WAKE_CONFIG)) begin
                wake_config <= wbyte & MASK_WAKE_CONFIG;
            end
            if (wr_to(IDX_SHUTDOWN)) begin
                shutdown_req_bit <= wbyte[SHUTDOWN_REQ_BIT];
            end
            if (wr_to(IDX_FLAG_CLEAR)) begin
                rc_osc_cal_enable <= wbyte[CAL_ENABLE_BIT];
            end
        end
    end

    // Clear strobe reads back as zero: it acts once per write
    assign flag_clear_pulse = wr_to(IDX_FLAG_CLEAR)
                              && wbyte[FLAG_CLEAR_BIT];

    // ======================================================
    // Pull-in limit and received power
    // ======================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pull_in_limit <= RST_FREQ_LIMIT;
        end else if (receive_state_entry) begin
            // Processor load wins over a software write that lands
            // in the same cycle
            pull_in_limit <= if_bandwidth_khz[8:1];
        end else if (wr_to(IDX_FREQ_LIMIT)) begin
            pull_in_limit <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_power_readback <= '0;
        end else if (packet_received) begin
            rx_power_readback <= rx_power_value;
        end
    end

    // ======================================================
    // Wake-up countdown
    // ======================================================
    logic [TIMER_W-1:0] counter;
    logic               tick_prev;
    logic               tick_edge;
    logic               timer_run;
    logic               hit_zero;
    logic               timeout_latched_flag;
    logic               cold_start_flag;

    assign timer_run = wake_config[CFG_RUN_BIT];
    assign tick_edge = pin_sync[PIN_TICK] && !tick_prev;
    assign hit_zero  = timer_run && tick_edge
                       && (counter == TIMER_W'(1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_prev <= 1'b0;
        end else begin
            tick_prev <= pin_sync[PIN_TICK];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter <= '0;
        end else if (wr_to(IDX_RELOAD_LOW)) begin
            counter <= {reload_high_staged, wbyte};
        end else if (timer_run && tick_edge) begin
            if (counter == '0) begin
                counter <= reload_value;
            end else begin
                counter <= counter - TIMER_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_live_event <= 1'b0;
            wake_event         <= 1'b0;
        end else begin
            timeout_live_event <= (counter == '0);
            // Timeouts while unarmed still latch, but wake nobody
            wake_event <= hit_zero && wake_config[CFG_ARM_BIT];
        end
    end

    // Hardware set wins over a same-cycle software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_latched_flag <= 1'b0;
            cold_start_flag      <= 1'b0;
        end else begin
            if (hit_zero) begin
                timeout_latched_flag <= 1'b1;
            end else if (flag_clear_pulse) begin
                timeout_latched_flag <= 1'b0;
            end
            if (pin_sync[PIN_COLD]) begin
                cold_start_flag <= 1'b1;
            end else if (flag_clear_pulse) begin
                cold_start_flag <= 1'b0;
            end
        end
    end

    // ======================================================
    // Status byte
    // ======================================================
    logic [7:0] status_byte;

    always_comb begin
        status_byte                  = '0;
        status_byte[ST_LIVE_BIT]     = timeout_live_event;
        status_byte[ST_LATCHED_BIT]  = timeout_latched_flag;
        status_byte[ST_COLD_BIT]     = cold_start_flag;
        status_byte[ST_LEVEL_BIT]    = pin_sync[PIN_LEVEL];
        status_byte[ST_SETTLED_BIT]  = pin_sync[PIN_SETTLED]
                                       && wake_config[CFG_XTAL_EN_BIT];
        status_byte[ST_CAL_DONE_BIT] = pin_sync[PIN_DONE]
                                       && rc_osc_cal_enable;
        status_byte[ST_CAL_FAIL_BIT] = pin_sync[PIN_FAIL]
                                       && rc_osc_cal_enable;
    end

    // ======================================================
    // Read mux and APB answer
    // ======================================================
    logic [7:0] read_byte;

    always_comb begin
        read_byte = 8'h00;
        unique case (reg_index)
            IDX_FLAG_CLEAR:  read_byte = {6'h00, rc_osc_cal_enable, 1'b0};
            IDX_STATUS:      read_byte = status_byte;
            IDX_RX_STRENGTH: read_byte = rx_power_readback;
            IDX_FREQ_LIMIT:  read_byte = pull_in_limit;
            IDX_IMAGE_CAL:   read_byte = image_cal_reg;
            IDX_SHUTDOWN:    read_byte = {7'h00, shutdown_req_bit};
            IDX_RX_POWER:    read_byte = rx_power_reg;
            IDX_WAKE_CONFIG: read_byte = wake_config;
            default:         read_byte = 8'h00;  // write-only reads zero
        endcase
    end

    // One fixed wait-free access phase: answer prepared in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (setup_phase) begin
            pready  <= 1'b1;
            pslverr <= !hit;
            prdata  <= (hit && !pwrite) ? {24'h000000, read_byte} : '0;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ======================================================
    // Control outputs
    // ======================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_arm                       <= 1'b0;
            slow_crystal_osc_enable        <= 1'b0;
            image_cal_overwrite_enable     <= 1'b0;
            image_cal_frequency            <= '0;
            image_cal_level                <= '0;
            shutdown_initiate              <= 1'b0;
            converter_power_enable         <= 1'b0;
            strength_detector_power_enable <= 1'b0;
            if_filter_power_enable         <= 1'b0;
            mixer_power_enable             <= 1'b0;
            low_noise_amp_power_enable     <= 1'b0;
        end else begin
            wake_arm                <= wake_config[CFG_ARM_BIT];
            slow_crystal_osc_enable <= wake_config[CFG_XTAL_EN_BIT];
            image_cal_overwrite_enable <= image_cal_reg[IMG_OVERWRITE_BIT];
            image_cal_frequency <= image_cal_reg[IMG_FREQ_LSB +: 2];
            image_cal_level     <= image_cal_reg[IMG_LEVEL_LSB +: 3];
            // Held off while the host still owns the serial port
            shutdown_initiate <= shutdown_req_bit
                                 && pin_sync[PIN_CS];
            converter_power_enable         <= rx_power_reg[4];
            strength_detector_power_enable <= rx_power_reg[3];
            if_filter_power_enable         <= rx_power_reg[2];
            mixer_power_enable             <= rx_power_reg[1];
            low_noise_amp_power_enable     <= rx_power_reg[0];
        end
    end
endmodule // wtac_regs
`default_nettype wire

// ===== hdl/wtac_sync3.sv
`default_nettype none
module wtac_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            // A bit moves only once the two later stages agree
            sync_out <= (stage2 & stage3) | (sync_out & (stage2 | stage3));
        end
    end
endmodule // wtac_sync3
`default_nettype wire

// ===== verification/test_wake_timer_aux_control_regs.sv
`default_nettype none
module test_wake_timer_aux_control_regs
    import wtac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        tck, lvl, stl, done, fail, cold, cs, pkt, rse;
    logic [7:0]  rxp, lim;
    logic [8:0]  bw;
    logic        wake, live, arm, xen, calen, ovw, shut;
    logic [1:0]  frq;
    logic [2:0]  ilv;
    logic [4:0]  pe;
    int          errors, tests_run, wakes, w0, n;
    logic [7:0]  v, d;
    logic        e;
    logic [11:0] ri[8] = '{IDX_RELOAD_LOW, IDX_FLAG_CLEAR, IDX_STATUS,
        IDX_RX_STRENGTH, IDX_FREQ_LIMIT, IDX_IMAGE_CAL, IDX_SHUTDOWN,
        IDX_RX_POWER};
    logic [7:0]  rv[8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h32, 8'h00, 8'h00,
        8'h00};

    wtac_regs i_wtac_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wake_tick(tck), .slow_crystal_level(lvl),
        .slow_crystal_settled(stl), .rc_osc_cal_done(done),
        .rc_osc_cal_fail(fail), .cold_start(cold), .chip_select(cs),
        .packet_received(pkt), .rx_power_value(rxp),
        .receive_state_entry(rse), .if_bandwidth_khz(bw),
        .wake_event(wake), .timeout_live_event(live), .wake_arm(arm),
        .slow_crystal_osc_enable(xen), .rc_osc_cal_enable(calen),
        .pull_in_limit(lim), .image_cal_overwrite_enable(ovw),
        .image_cal_frequency(frq), .image_cal_level(ilv),
        .shutdown_initiate(shut), .converter_power_enable(pe[4]),
        .strength_detector_power_enable(pe[3]),
        .if_filter_power_enable(pe[2]), .mixer_power_enable(pe[1]),
        .low_noise_amp_power_enable(pe[0]));

    always #4 pclk = ~pclk;
    always @(posedge pclk) if (wake === 1'b1) wakes++;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // ======================================================
    // Bus master: holds the request until pready is seen
    task automatic bus(input logic [13:0] a, input logic w,
                       input logic [7:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= a; pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin errors++; stop_test(); end
        d = prdata[7:0]; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wrr(input logic [11:0] i, input logic [7:0] wd);
        bus({i, 2'b00}, 1'b1, wd);
    endtask

    task automatic rdc(input logic [11:0] i, input logic [7:0] m,
                       input logic [7:0] x);
        bus({i, 2'b00}, 1'b0, 8'h00);
        chk8(d & m, x);
    endtask

    // Sync chain needs 4 edges; a tick is held past that on both levels
    task automatic tick();
        tck <= 1'b1; cyc(6); tck <= 1'b0; cyc(6);
    endtask

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = '0; pwdata = '0; {tck, lvl, stl, done, fail, cold} = '0;
        cs = 0; pkt = 0; rse = 0; rxp = '0; bw = '0;
        errors = 0; tests_run = 0; wakes = 0;
        void'($urandom(32'hef3a));
        cyc(8);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) rdc(ri[i], 8'hFF, rv[i]);
        bus({12'h300, 2'b00}, 1'b0, 8'h00);
        chk8({7'h0, e}, 8'h01);
        bus({IDX_FLAG_CLEAR, 2'b10}, 1'b1, 8'h02);
        rdc(IDX_FLAG_CLEAR, 8'hFF, 8'h00);
        $display("test reset and refusal done");
        for (int i = 0; i < 8; i++) begin
            v = {3'($urandom), 2'(i), 3'(i)};
            wrr(IDX_IMAGE_CAL, v);
            rdc(IDX_IMAGE_CAL, 8'hFF, v & 8'h3F);
            chk8({2'b0, ovw, frq, ilv}, v & 8'h3F);
            v = (i == 0) ? 8'hFF : 8'($urandom);
            wrr(IDX_RX_POWER, v);
            rdc(IDX_RX_POWER, 8'hFF, v & 8'h1F);
            chk8({3'b0, pe}, v & 8'h1F);
            wrr(IDX_FREQ_LIMIT, v);
            rdc(IDX_FREQ_LIMIT, 8'hFF, v);
            rxp <= 8'($urandom); pkt <= 1'b1; cyc(1); pkt <= 1'b0;
            rdc(IDX_RX_STRENGTH, 8'hFF, rxp);
            bw <= 9'($urandom); rse <= 1'b1; cyc(1); rse <= 1'b0;
            rdc(IDX_FREQ_LIMIT, 8'hFF, bw[8:1]);
        end
        $display("test config done");
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            {lvl, stl, done, fail} <= v[3:0];
            wrr(IDX_WAKE_CONFIG, {5'b0, v[6], 2'b00});
            wrr(IDX_FLAG_CLEAR, {6'b0, v[5], 1'b0});
            cyc(6);
            rdc(IDX_STATUS, 8'hFF, {1'b0, v[0] & v[5], v[1] & v[5],
                v[2] & v[6], v[3], 3'b001});
            chk8({6'b0, calen, xen}, {6'b0, v[5], v[6]});
        end
        cold <= 1'b1; cyc(6); cold <= 1'b0; cyc(6);
        rdc(IDX_STATUS, 8'h04, 8'h04);
        wrr(IDX_FLAG_CLEAR, 8'h01);
        rdc(IDX_STATUS, 8'h04, 8'h00);
        $display("test status done");
        wrr(IDX_WAKE_CONFIG, 8'h03);
        n = 1 + $urandom % 4;
        wrr(IDX_RELOAD_HIGH, 8'h00);
        wrr(IDX_RELOAD_LOW, 8'(n));
        rdc(IDX_RELOAD_LOW, 8'hFF, 8'h00);
        w0 = wakes;
        repeat (n - 1) tick();
        rdc(IDX_STATUS, 8'h03, 8'h00);
        tick();
        rdc(IDX_STATUS, 8'h03, 8'h03);
        chk8(8'(wakes - w0), 8'h01);
        tick();
        rdc(IDX_STATUS, 8'h03, 8'h02);
        wrr(IDX_FLAG_CLEAR, 8'h01);
        wrr(IDX_WAKE_CONFIG, 8'h02);
        w0 = wakes;
        repeat (n) tick();
        rdc(IDX_STATUS, 8'h03, 8'h03);
        chk8(8'(wakes - w0), 8'h00);
        wrr(IDX_WAKE_CONFIG, 8'h00);
        wrr(IDX_RELOAD_HIGH, 8'h01);
        rdc(IDX_STATUS, 8'h01, 8'h01);
        wrr(IDX_RELOAD_LOW, 8'h00);
        rdc(IDX_STATUS, 8'h01, 8'h00);
        $display("test timer done");
        wrr(IDX_SHUTDOWN, 8'h01);
        rdc(IDX_SHUTDOWN, 8'hFF, 8'h01);
        chk8({7'h0, shut}, 8'h00);
        cs <= 1'b1; cyc(6);
        chk8({7'h0, shut}, 8'h01);
        wrr(IDX_SHUTDOWN, 8'h00); cyc(2);
        chk8({7'h0, shut}, 8'h00);
        $display("test shutdown done");
        stop_test();
    end
endmodule // test_wake_timer_aux_control_regs
`default_nettype wire

// ===== verification/wtac_props.sv
`default_nettype none
module wtac_props
    import wtac_pkg::*;
#(
    parameter int ADDR_W = 14
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              receive_state_entry,
    input wire logic [8:0]        if_bandwidth_khz,
    input wire logic              wake_event,
    input wire logic              timeout_live_event,
    input wire logic              wake_arm,
    input wire logic [7:0]        pull_in_limit,
    input wire logic              image_cal_overwrite_enable,
    input wire logic [1:0]        image_cal_frequency,
    input wire logic [2:0]        image_cal_level,
    input wire logic              converter_power_enable,
    input wire logic              strength_detector_power_enable,
    input wire logic              if_filter_power_enable,
    input wire logic              mixer_power_enable,
    input wire logic              low_noise_amp_power_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       wr;
    logic [4:0] pwr;
    assign wr  = psel && penable && pready && pwrite;
    assign pwr = {converter_power_enable, strength_detector_power_enable,
                  if_filter_power_enable, mixer_power_enable,
                  low_noise_amp_power_enable};
    // ======================================================
    // Bus handshake
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready missing");
    property p_once; pready |=> !pready; endproperty
    a_once: assert property (p_once) else $error("pready too long");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper data set");
    property p_align; psel && !penable && paddr[1:0] != 2'b00 |=> pslverr;
    endproperty
    a_align: assert property (p_align) else $error("misaligned taken");
    // ======================================================
    // Register effects
    property p_limit;
        receive_state_entry |=>
            pull_in_limit == 8'($past(if_bandwidth_khz) >> 1);
    endproperty
    a_limit: assert property (p_limit) else $error("limit load");
    property p_power; wr && paddr == {IDX_RX_POWER, 2'b00} |-> ##2
        pwr == 5'($past(pwdata, 2)); endproperty
    a_power: assert property (p_power) else $error("power enables");
    property p_image; wr && paddr == {IDX_IMAGE_CAL, 2'b00} |-> ##2
        {image_cal_overwrite_enable, image_cal_frequency,
         image_cal_level} == 6'($past(pwdata, 2)); endproperty
    a_image: assert property (p_image) else $error("image");
    property p_arm; wake_event |-> wake_arm || $past(wake_arm); endproperty
    a_arm: assert property (p_arm) else $error("wake unarmed");
    property p_wake; wake_event |=> timeout_live_event; endproperty
    a_wake: assert property (p_wake) else $error("wake not at zero");
    property p_rst; $rose(presetn) |-> pull_in_limit == 8'h32 && pwr == 5'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    c_wake: cover property (wake_event);
    c_err: cover property (pslverr);
    c_entry: cover property (receive_state_entry);
endmodule // wtac_props

bind wtac_regs wtac_props #(.ADDR_W(ADDR_W)) i_wtac_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .receive_state_entry, .if_bandwidth_khz,
    .wake_event, .timeout_live_event, .wake_arm, .pull_in_limit,
    .image_cal_overwrite_enable, .image_cal_frequency, .image_cal_level,
    .converter_power_enable, .strength_detector_power_enable,
    .if_filter_power_enable, .mixer_power_enable,
    .low_noise_amp_power_enable);
`default_nettype wire
